/* File: hdl/ipc_pkg.sv */
// Package: register map, field layout and types of the interrupt controller
`default_nettype none
package ipc_pkg;
    localparam int         NSRC         = 6;
    localparam int         ADDR_W       = 8;
    localparam int         GATE_BIT     = 7;
    // Register byte offsets
    localparam logic [7:0] OFS_ENABLE   = 8'ha8;
    localparam logic [7:0] OFS_PRIO_LOW = 8'hb8;
    localparam logic [7:0] OFS_PRIO_HI  = 8'hc0;
    localparam logic [7:0] OFS_STATUS   = 8'hc4;
    localparam logic [7:0] OFS_MASK     = 8'hc8;
    localparam logic [7:0] OFS_STATE    = 8'hcc;
    localparam logic [7:0] OFS_EN_SET   = 8'hd0;
    localparam logic [7:0] OFS_EN_CLR   = 8'hd4;
    // Writable bits and reset values
    localparam logic [7:0] ENABLE_MASK  = 8'hbf;
    localparam logic [7:0] PRIO_MASK    = 8'h3f;
    localparam logic [7:0] RST_ENABLE   = 8'h00;
    localparam logic [7:0] RST_PRIO     = 8'h00;
    localparam logic [5:0] RST_FLAGS    = 6'h00;
    // Sources whose request is a pulse held sticky until acknowledged
    localparam logic [5:0] PULSE_SRC    = 6'h2a;
    localparam logic [5:0] ONE_SRC      = 6'h01;
    // Source indices, also the polling order
    localparam int         SRC_EXT0     = 0;
    localparam int         SRC_TIM0     = 1;
    localparam int         SRC_EXT1     = 2;
    localparam int         SRC_TIM1     = 3;
    localparam int         SRC_SER      = 4;
    localparam int         SRC_TIM2     = 5;
    // Bus responses
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_SLVERR  = 2'h2;

    typedef logic [2:0] ipc_vec_t;
    typedef logic [1:0] ipc_lvl_t;

    typedef struct packed {
        logic     valid;
        ipc_vec_t vector;
        ipc_lvl_t level;
    } ipc_grant_t;
endpackage
`default_nettype wire

/* File: hdl/ipc_resolver.sv */
// Priority resolver: picks the winning request and checks preemption
`default_nettype none
module ipc_resolver
    import ipc_pkg::*;
#(
    parameter int N = NSRC
) (
    // Gated requests and priority bits
    input  wire logic [N-1:0] req,
    input  wire logic [N-1:0] prio_low,
    input  wire logic [N-1:0] prio_high,
    // Handler in progress
    input  wire logic         busy,
    input  wire ipc_lvl_t     cur_level,
    // Selection
    output var  ipc_grant_t   pick
);
    ipc_lvl_t lvl [N];

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_lvl
            assign lvl[g] = {prio_high[g], prio_low[g]};
        end
    endgenerate

    always_comb begin
        logic     found;
        ipc_vec_t best;
        ipc_lvl_t blvl;
        found = 1'b0;
        best  = '0;
        blvl  = '0;
        // Strictly greater keeps the lowest index within a level
        for (int i = 0; i < N; i++) begin
            if (req[i] && (!found || lvl[i] > blvl)) begin
                found = 1'b1;
                best  = ipc_vec_t'(i);
                blvl  = lvl[i];
            end
        end
        pick.vector = best;
        pick.level  = blvl;
        pick.valid  = found && (!busy || blvl > cur_level);
    end
endmodule
`default_nettype wire

/* File: hdl/ipc_top.sv */
// Interrupt controller top: AXI4-Lite registers, request gating, service
`default_nettype none
module ipc_top
    import ipc_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Request sources
    input  wire logic              ext_request0_n,
    input  wire logic              ext_request1_n,
    input  wire logic              timer0_ovf,
    input  wire logic              timer1_ovf,
    input  wire logic              timer2_ovf,
    input  wire logic              serial_irq,
    // Core vector port
    output ipc_grant_t             grant,
    input  wire logic              cpu_ack,
    input  wire logic              cpu_reti,
    // Event interrupt line
    output logic                   irq
);
    logic [7:0]        ie;
    logic [7:0]        prio_low;
    logic [7:0]        prio_high;
    logic [5:0]        status;
    logic [5:0]        mask;
    logic [5:0]        pend;
    logic [5:0]        req_raw;
    logic [5:0]        req_q;
    logic [5:0]        elig;
    logic [3:0]        in_service;
    logic [3:0]        next_service;
    logic [1:0]        ext_meta;
    logic [1:0]        ext_sync;
    logic              busy;
    ipc_lvl_t          cur_level;
    ipc_grant_t        pick;
    logic              take;
    logic [5:0]        ack_clr;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] waddr;
    logic [7:0]        wdat;
    logic              wlane;
    logic              do_write;
    logic              wr_lane;
    logic [7:0]        ie_q;

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = (a == OFS_ENABLE) || (a == OFS_PRIO_LOW) ||
                 (a == OFS_PRIO_HI) || (a == OFS_STATUS) ||
                 (a == OFS_MASK) || (a == OFS_STATE) ||
                 (a == OFS_EN_SET) || (a == OFS_EN_CLR);
    endfunction

    // Reserved bits read as zero
    function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a);
        rd_word = '0;
        case (a)
            OFS_ENABLE:   rd_word[7:0]  = ie;
            OFS_PRIO_LOW: rd_word[7:0]  = prio_low;
            OFS_PRIO_HI:  rd_word[7:0]  = prio_high;
            OFS_STATUS:   rd_word[5:0]  = status;
            OFS_MASK:     rd_word[5:0]  = mask;
            OFS_STATE: begin
                rd_word[5:0]  = req_raw;
                rd_word[11:8] = in_service;
            end
            default:      rd_word = '0;
        endcase
    endfunction

    // Pin synchroniser; pins are active low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta <= '0;
            ext_sync <= '0;
        end else begin
            ext_meta <= ~{ext_request1_n, ext_request0_n};
            ext_sync <= ext_meta;
        end
    end

    // Timer flags stay sticky until vectored; set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend <= RST_FLAGS;
        end else begin
            pend <= ({timer2_ovf, 1'b0, timer1_ovf, 1'b0, timer0_ovf, 1'b0}
                     | (pend & ~ack_clr)) & PULSE_SRC;
        end
    end

    // Pins and serial are level requests, so the source clears them
    assign req_raw = pend | {1'b0, serial_irq, 1'b0, ext_sync[1], 1'b0,
                             ext_sync[0]};
    assign elig    = req_raw & ie[5:0] & {NSRC{ie[GATE_BIT]}};
    assign take    = cpu_ack && grant.valid;
    assign ack_clr = take ? (ONE_SRC << grant.vector) : '0;

    ipc_resolver #(
        .N         (NSRC)
    ) u_resolver (
        .req       (elig),
        .prio_low  (prio_low[5:0]),
        .prio_high (prio_high[5:0]),
        .busy      (busy),
        .cur_level (cur_level),
        .pick      (pick)
    );

    // Level of the handler in progress
    assign busy = |in_service;
    always_comb begin
        cur_level = 2'd0;
        for (int l = 1; l < 4; l++) begin
            if (in_service[l]) begin
                cur_level = ipc_lvl_t'(l);
            end
        end
    end

    // Return drops the top level; a new acceptance wins over it
    always_comb begin
        next_service = in_service;
        if (cpu_reti && busy) begin
            next_service[cur_level] = 1'b0;
        end
        if (take) begin
            next_service[grant.level] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_service <= '0;
        end else begin
            in_service <= next_service;
        end
    end

    // Grant is withdrawn the cycle after acceptance, not offered twice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            grant <= '0;
        end else begin
            grant       <= pick;
            grant.valid <= pick.valid && !take;
        end
    end

    // Write address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            aw_full       <= 1'b0;
            waddr         <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_full       <= 1'b1;
            waddr         <= s_axi_awaddr;
        end else if (do_write) begin
            aw_full       <= 1'b0;
        end else if (!aw_full && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b0;
            w_full       <= 1'b0;
            wdat         <= '0;
            wlane        <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_full       <= 1'b1;
            wdat         <= s_axi_wdata[7:0];
            wlane        <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_full       <= 1'b0;
        end else if (!w_full && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
        end
    end

    assign do_write = aw_full && w_full && !s_axi_bvalid;
    assign wr_lane  = do_write && wlane;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(waddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read port answers one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word(s_axi_araddr);
            s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Enable register with set and clear aliases for single bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie <= RST_ENABLE;
        end else if (wr_lane) begin
            case (waddr)
                OFS_ENABLE: ie <= wdat & ENABLE_MASK;
                OFS_EN_SET: ie <= (ie | wdat) & ENABLE_MASK;
                OFS_EN_CLR: ie <= ie & ~wdat;
                default:    ie <= ie;
            endcase
        end
    end

    // Reserved bits are dropped so a stray one cannot alter a level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_low  <= RST_PRIO;
            prio_high <= RST_PRIO;
        end else if (wr_lane) begin
            if (waddr == OFS_PRIO_LOW) begin
                prio_low <= wdat & PRIO_MASK;
            end
            if (waddr == OFS_PRIO_HI) begin
                prio_high <= wdat & PRIO_MASK;
            end
        end
    end

    // Request edges are sticky events, write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q  <= RST_FLAGS;
            status <= RST_FLAGS;
            mask   <= RST_FLAGS;
            irq    <= 1'b0;
        end else begin
            req_q  <= req_raw;
            status <= (status & ~((wr_lane && waddr == OFS_STATUS) ?
                      wdat[5:0] : RST_FLAGS)) | (req_raw & ~req_q);
            if (wr_lane && waddr == OFS_MASK) begin
                mask <= wdat[5:0];
            end
            irq    <= |(status & mask);
        end
    end

    // Helper only read by the checks below
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie_q <= RST_ENABLE;
        end else begin
            ie_q <= ie;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_ie_write;
        wr_lane && waddr == OFS_ENABLE;
    endsequence

    sequence s_accept;
        cpu_ack && grant.valid;
    endsequence

    sequence s_prio_write;
        wr_lane && waddr == OFS_PRIO_LOW;
    endsequence

    a_gate_closed: assert property (
        !ie[GATE_BIT] |=> !grant.valid)
        else $error("grant issued while global gate closed");

    a_source_enable: assert property (
        grant.valid |-> ie_q[grant.vector] && ie_q[GATE_BIT])
        else $error("grant for a disabled source");

    a_strict_preempt: assert property (
        grant.valid |-> !$past(busy) || grant.level > $past(cur_level))
        else $error("preemption by equal or lower level");

    a_top_level_hold: assert property (
        in_service[3] |=> !grant.valid)
        else $error("top level handler preempted");

    a_accept_marks: assert property (
        s_accept |=> in_service[$past(grant.level)] && !grant.valid)
        else $error("acceptance not recorded");

    a_ie_write: assert property (
        s_ie_write |=> ie == ($past(wdat) & ENABLE_MASK))
        else $error("enable register write lost");

    a_prio_write: assert property (
        s_prio_write |=> prio_low[7:6] == 2'b00
                         && prio_low[5:0] == $past(wdat[5:0]))
        else $error("priority write wrong");

    a_reset_clear: assert property (disable iff (1'b0)
        !aresetn |=> ie == RST_ENABLE && !grant.valid && !irq)
        else $error("reset did not clear controller");

    a_irq_line: assert property (
        (status & mask) != 6'h00 |=> irq)
        else $error("interrupt line missed an event");
endmodule
`default_nettype wire

/* File: sim/ipc_core_model.sv */
// Behavioural core: takes granted vectors and returns from handlers
`default_nettype none
module ipc_core_model
    import ipc_pkg::*;
(
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Behaviour controls
    input  wire logic       ack_en,
    input  wire logic       ret_en,
    // Vector port
    input  wire ipc_grant_t grant,
    output logic            cpu_ack,
    output logic            cpu_reti,
    // Observation
    output ipc_vec_t        last_vec,
    output logic [7:0]      n_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] depth;
    logic       take;
    // Holding ack_en low makes a slow core
    assign take = cpu_ack && grant.valid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_ack  <= 1'b0;
            cpu_reti <= 1'b0;
            depth    <= 4'h0;
            n_taken  <= 8'h00;
            last_vec <= 3'h0;
        end else begin
            cpu_ack  <= ack_en && grant.valid && !cpu_ack;
            cpu_reti <= ret_en && depth != 4'h0 && !cpu_reti && !cpu_ack;
            depth    <= depth + {3'h0, take} - {3'h0, cpu_reti};
            if (take) begin
                last_vec <= grant.vector;
                n_taken  <= n_taken + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// Testbench: registers, request resolution, preemption, event line
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ipc_pkg::*;
    typedef struct packed {
        logic [7:0] ie, pl, ph;
        logic [5:0] rq;
        logic       v;
        logic [2:0] vec;
        logic [1:0] lvl;
    } ipc_row_t;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        ext0_n, ext1_n, tim0, tim1, tim2, ser;
    logic        cpu_ack, cpu_reti, ack_en, ret_en;
    logic [7:0]  awaddr, araddr, n_taken, k;
    logic [31:0] wdata, rdata, got;
    logic [1:0]  bresp, rresp, resp;
    logic [3:0]  wstrb;
    ipc_grant_t  grant;
    ipc_vec_t    last_vec;
    int          miscompares, n_compared;
    ipc_row_t    rows [10] = '{
        '{8'hbf, 8'h00, 8'h00, 6'h3f, 1'b1, 3'h0, 2'h0},
        '{8'hbf, 8'h20, 8'h20, 6'h3f, 1'b1, 3'h5, 2'h3},
        '{8'hbf, 8'h10, 8'h00, 6'h3f, 1'b1, 3'h4, 2'h1},
        '{8'hbf, 8'h00, 8'h08, 6'h38, 1'b1, 3'h3, 2'h2},
        '{8'hbf, 8'h00, 8'h00, 6'h3c, 1'b1, 3'h2, 2'h0},
        '{8'hbe, 8'h00, 8'h00, 6'h3f, 1'b1, 3'h1, 2'h0},
        '{8'h3f, 8'h00, 8'h00, 6'h3f, 1'b0, 3'h0, 2'h0},
        '{8'h80, 8'h00, 8'h00, 6'h3f, 1'b0, 3'h0, 2'h0},
        '{8'ha2, 8'h02, 8'h20, 6'h22, 1'b1, 3'h5, 2'h2},
        '{8'hbf, 8'h10, 8'h20, 6'h30, 1'b1, 3'h5, 2'h2}};

    ipc_top ipc_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_request0_n(ext0_n),
        .ext_request1_n(ext1_n), .timer0_ovf(tim0), .timer1_ovf(tim1),
        .timer2_ovf(tim2), .serial_irq(ser), .grant(grant),
        .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .irq(irq));
    ipc_core_model ipc_core_model_inst (.aclk(aclk), .aresetn(aresetn),
        .ack_en(ack_en), .ret_en(ret_en), .grant(grant), .cpu_ack(cpu_ack),
        .cpu_reti(cpu_reti), .last_vec(last_vec), .n_taken(n_taken));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            aw = aw | awready;
            w = w | wready;
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        got = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Timer pulses last one cycle; pins and serial hold their level
    task automatic src(input logic [5:0] r);
        ext0_n <= ~r[0];
        ext1_n <= ~r[2];
        ser <= r[4];
        {tim2, tim1, tim0} <= {r[5], r[3], r[1]};
        @(posedge aclk);
        {tim2, tim1, tim0} <= 3'h0;
    endtask
    // Sticky timer requests linger, so each pending timer source is served and returned; pins and serial are dropped first
    task automatic drain;
        src(6'h00);
        wr(8'ha8, 8'hbf);
        ack_en <= 1'b1;
        ret_en <= 1'b1;
        cyc(40);
        ack_en <= 1'b0;
        ret_en <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        give_verdict();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {tim0, tim1, tim2, ser, ack_en, ret_en} = 6'h00;
        {ext0_n, ext1_n} = 2'h3;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'h1;
        cyc(8);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'ha8); chk(got, 32'h0);
        rd(8'hb8); chk(got, 32'h0);
        wr(8'ha8, 8'hbf);
        rd(8'ha8); chk(got, 32'hbf);
        wr(8'hd4, 8'h21);
        rd(8'ha8); chk(got, 32'h9e);
        wr(8'hd0, 8'h01);
        rd(8'ha8); chk(got, 32'h9f);
        wr(8'hb8, 8'h3f);
        rd(8'hb8); chk(got, 32'h3f);
        // Write without its byte lane is answered but changes nothing
        wstrb <= 4'h0;
        wr(8'hb8, 8'h00);
        chk(resp, 32'h0);
        wstrb <= 4'h1;
        rd(8'hb8);
        chk(got, 32'h3f);
        chk(resp, 32'h0);
        // State register is read only
        wr(8'hcc, 8'h3f);
        chk(resp, 32'h0);
        wr(8'h10, 8'h01); chk(resp, 32'h2);
        rd(8'h10); chk({got[29:0], resp}, 32'h2);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(8'ha8); chk(got, 32'h0);
        $display("test registers done");
        foreach (rows[i]) begin
            wr(8'ha8, rows[i].ie);
            wr(8'hb8, rows[i].pl);
            wr(8'hc0, rows[i].ph);
            src(rows[i].rq);
            // Pins arrive late through the synchroniser; let all settle
            cyc(6);
            chk(grant.valid, rows[i].v);
            if (rows[i].v) chk(grant[4:0], {rows[i].vec, rows[i].lvl});
            drain();
        end
        $display("test resolution done");
        wr(8'ha8, 8'hbf);
        wr(8'hb8, 8'h11);
        wr(8'hc0, 8'h04);
        ack_en <= 1'b1;
        src(6'h10);
        cyc(6);
        chk(last_vec, 32'h4);
        k = n_taken;
        src(6'h11);
        cyc(8);
        chk(n_taken, k);
        src(6'h15);
        cyc(8);
        chk(last_vec, 32'h2);
        wr(8'hc0, 8'h05);
        cyc(8);
        chk(last_vec, 32'h0);
        k = n_taken;
        wr(8'hc0, 8'h15);
        cyc(8);
        chk(n_taken, k);
        // Levels 1, 2 and 3 in service; pins and serial still raised
        rd(8'hcc);
        chk(got, 32'he15);
        drain();
        $display("test preemption done");
        wr(8'hc8, 8'h00);
        wr(8'hc4, 8'h3f);
        cyc(2);
        chk(irq, 32'h0);
        wr(8'hc8, 8'h02);
        src(6'h02);
        cyc(3);
        chk(irq, 32'h1);
        rd(8'hc4); chk(got, 32'h2);
        wr(8'hc8, 8'h00);
        cyc(2);
        chk(irq, 32'h0);
        wr(8'hc8, 8'h02);
        cyc(2);
        chk(irq, 32'h1);
        wr(8'hc4, 8'h02);
        cyc(2);
        chk(irq, 32'h0);
        rd(8'hc4); chk(got, 32'h0);
        $display("test event line done");
        give_verdict();
    end
endmodule
`default_nettype wire
